// ===== design/emb_defs.vh
// Purpose: constants for the external memory bus strobe generator
// Assumes: one clock, one machine cycle = 12 oscillator states of one clock each
// Notes: each phase count is in clock cycles
`ifndef EMB_DEFS_VH
`define EMB_DEFS_VH
`define EMB_CYC_LEN 4'hC
`define EMB_ALE_A 4'h0
`define EMB_ALE_B 4'h6
`define EMB_FETCH_A 4'h2
`define EMB_FETCH_B 4'h8
`define EMB_STROBE_LEN 4'h3
`define EMB_INT_LIMIT 16'h8000
`define EMB_PH_IDLE 2'h0
`define EMB_PH_ADDR 2'h1
`define EMB_PH_DATA 2'h2
`endif

// ===== design/emb_strobes.v
// Purpose: pin timing of the external program and data memory bus
// Assumes: the core gives pc, a data move request with address and write data
// Notes: one machine cycle is twelve clocks; a data move takes the second machine cycle
//   the address latch keeps pulsing during internal execution; there is no quiet mode
//   with the select strapped high, a pc that crosses the internal limit mid-strobe ends that strobe at once
//
// What this block does
// - program fetch strobe reads external code; address on port 0 and port 2
// - strobe pulses twice per machine cycle while fetching externally
// - an external data move drops two fetch strobe pulses
// - strobe stays high when no external fetch runs
// - data pointer moves put the high address byte on port 2
// - write strobe on port 3 bit 6 during external data writes
// - read strobe on port 3 bit 7 during external data reads
// - address latch pulses every six clocks except in the data half of a data move
// - port 0 carries low address first, then data
// - external access select latched at reset; internal fetch only below 32768
`timescale 1ns/10ps
`include "emb_defs.vh"
module emb_strobes #(
  parameter AW = 16
) (
  clock,
  rst_b,
  external_access_select,
  pc,
  move_req,
  move_write,
  move_wide,
  move_addr,
  move_wdata,
  port0_in,
  move_ack,
  move_rdata,
  program_fetch_strobe_b,
  ale,
  wr_b,
  rd_b,
  port0_out,
  port0_oe,
  port2_out
);
  input wire clock;
  input wire rst_b;
  input wire external_access_select;
  input wire [AW-1:0] pc;
  input wire move_req;
  input wire move_write;
  input wire move_wide;
  input wire [AW-1:0] move_addr;
  input wire [7:0] move_wdata;
  input wire [7:0] port0_in;
  output reg move_ack;
  output reg [7:0] move_rdata;
  output reg program_fetch_strobe_b;
  output reg ale;
  output reg wr_b;
  output reg rd_b;
  output reg [7:0] port0_out;
  output reg port0_oe;
  output reg [7:0] port2_out;

  reg [3:0] state_reg;
  reg in_reset_reg;
  reg ext_sel_reg;
  reg move_reg;
  reg mv_write_reg;
  reg mv_wide_reg;
  reg [AW-1:0] mv_addr_reg;
  reg [7:0] mv_wdata_reg;
  wire ext_fetch;
  wire cyc_end;
  wire strobe_start;
  wire [3:0] rel;
  wire hold;
  wire ale_slot;
  wire strobe_stop;
  wire data_slot;
  wire read_sample;

  // fetch goes outside when strapped low, or when pc reaches the internal limit
  assign ext_fetch = ~ext_sel_reg | (pc >= `EMB_INT_LIMIT);
  assign cyc_end = (state_reg == (`EMB_CYC_LEN - 4'h1));
  assign strobe_start = (state_reg == `EMB_FETCH_A) | (state_reg == `EMB_FETCH_B);
  // offset inside the half cycle, used to time the strobes
  assign rel = (state_reg >= `EMB_ALE_B) ? (state_reg - `EMB_ALE_B) : state_reg;
  // the cycle after release is held as well, so counter and pins restart together
  // and the first fetch strobe always follows a latch pulse with its address
  assign hold = ~rst_b | in_reset_reg;
  // latch slots at the start of each half cycle
  assign ale_slot = (state_reg == `EMB_ALE_A) | (state_reg == `EMB_ALE_B);
  // a fetch strobe closes three clocks after it opens, in either half
  assign strobe_stop = (rel >= (`EMB_FETCH_A + `EMB_STROBE_LEN));
  // data strobe window: one clock into the data half, three clocks long
  assign data_slot = (state_reg >= `EMB_ALE_B) & (rel >= 4'h1) & (rel <= `EMB_STROBE_LEN);
  // read data is taken while the read strobe is still low, one clock before it rises
  assign read_sample = move_reg & ~mv_write_reg &
                       (state_reg == (`EMB_ALE_B + `EMB_STROBE_LEN));

  // strap capture: the select pin is sampled while reset is held, kept afterwards
  always @(posedge clock) begin
    in_reset_reg <= ~rst_b;
    if (!rst_b) begin
      ext_sel_reg <= external_access_select;
    end
  end

  // machine cycle counter: twelve clocks, restarted by reset and the cycle after it
  always @(posedge clock) begin
    if (hold) begin
      state_reg <= 4'h0;
    end else begin
      state_reg <= cyc_end ? 4'h0 : state_reg + 4'h1;
    end
  end

  // move capture: a move occupies one whole machine cycle and is taken only at
  // the boundary; a request standing at the end of a move waits one fetch cycle
  always @(posedge clock) begin
    if (hold) begin
      move_reg <= 1'b0;
      mv_write_reg <= 1'b0;
      mv_wide_reg <= 1'b0;
      mv_addr_reg <= {AW{1'b0}};
      mv_wdata_reg <= 8'h00;
    end else if (cyc_end) begin
      move_reg <= move_req & ~move_reg;
      mv_write_reg <= move_write;
      mv_wide_reg <= move_wide;
      mv_addr_reg <= move_addr;
      mv_wdata_reg <= move_wdata;
    end
  end

  // acknowledge: one clock at the end of the move's machine cycle
  always @(posedge clock) begin
    if (hold) begin
      move_ack <= 1'b0;
    end else begin
      move_ack <= cyc_end & move_reg;
    end
  end

  // read data: kept until the next read, so the core may pick it up late
  always @(posedge clock) begin
    if (hold) begin
      move_rdata <= 8'h00;
    end else if (read_sample) begin
      move_rdata <= port0_in;
    end
  end

  // address latch pulse at each half cycle start; the data half of a move stays quiet
  always @(posedge clock) begin
    if (hold) begin
      ale <= 1'b0;
    end else begin
      ale <= ale_slot & ~(move_reg & (state_reg == `EMB_ALE_B));
    end
  end

  // fetch strobe: low three clocks from each fetch slot; a move or internal
  // execution leaves it high, so code memory never sees a stray read
  always @(posedge clock) begin
    if (hold) begin
      program_fetch_strobe_b <= 1'b1;
    end else if (move_reg) begin
      program_fetch_strobe_b <= 1'b1;
    end else if (!ext_fetch) begin
      program_fetch_strobe_b <= 1'b1;
    end else if (strobe_start) begin
      program_fetch_strobe_b <= 1'b0;
    end else if (strobe_stop) begin
      program_fetch_strobe_b <= 1'b1;
    end
  end

  // data strobes only inside a move's data half
  always @(posedge clock) begin
    if (hold) begin
      wr_b <= 1'b1;
      rd_b <= 1'b1;
    end else begin
      wr_b <= ~(move_reg & mv_write_reg & data_slot);
      rd_b <= ~(move_reg & ~mv_write_reg & data_slot);
    end
  end

  // port 2: high address byte; internal execution leaves the last value standing
  always @(posedge clock) begin
    if (hold) begin
      port2_out <= 8'h00;
    end else if (move_reg) begin
      port2_out <= mv_wide_reg ? mv_addr_reg[AW-1:8] : 8'h00;
    end else if (ext_fetch) begin
      port2_out <= pc[AW-1:8];
    end
  end

  // port 0: low address for the latch first, then data or a released bus
  always @(posedge clock) begin
    if (hold) begin
      port0_out <= 8'h00;
      port0_oe <= 1'b0;
    end else if (move_reg) begin
      if (state_reg < `EMB_ALE_B) begin
        // address half: the latch captures this byte
        port0_out <= mv_addr_reg[7:0];
        port0_oe <= 1'b1;
      end else begin
        // data half: drive only for a write, a read leaves the bus to memory
        port0_out <= mv_wdata_reg;
        port0_oe <= mv_write_reg;
      end
    end else if (ext_fetch) begin
      port0_out <= pc[7:0];
      port0_oe <= (rel < 4'h2);
    end else begin
      port0_oe <= 1'b0;
    end
  end
endmodule

// ===== test/emb_strobes_asserts.sv
// Purpose: pin timing checks for the external bus block
// Assumes: strap and pc change only while reset is held
// Notes: pins lag the phase count by one clock
`timescale 1ns/10ps
module emb_strobes_asserts (input wire clock, rst_b, external_access_select, ale, wr_b, rd_b,
  input wire program_fetch_strobe_b, port0_oe, input wire [15:0] pc);
  wire f = program_fetch_strobe_b; // short alias keeps properties readable
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // a strobe is three clocks low, then high again
  sequence f_low3; !f[*3] ##1 f; endsequence
  sequence ale_gap; !ale[*5]; endsequence
  fetch_width_a: assert property ($fell(f) |-> f_low3) else $error("fetch width");
  ale_gap_a: assert property (ale |=> ale_gap) else $error("ale spacing");
  fetch_ale_a: assert property ($fell(f) |-> $past(ale, 2)) else $error("no latch");
  int_fetch_a: assert property ($fell(f) |-> !external_access_select || pc[15])
    else $error("fetch inside");
  move_skip_a: assert property (!wr_b || !rd_b |-> f) else $error("fetch in move");
  wr_width_a: assert property ($fell(wr_b) |-> !wr_b[*3] ##1 wr_b) else $error("wr");
  rd_width_a: assert property ($fell(rd_b) |-> !rd_b[*3] ##1 rd_b) else $error("rd");
  addr_phase_a: assert property (ale && (!external_access_select || pc[15])
    |-> port0_oe[*2]) else $error("addr drive");
endmodule
bind emb_strobes emb_strobes_asserts chk (.clock, .rst_b, .external_access_select, .ale,
  .wr_b, .rd_b, .program_fetch_strobe_b, .port0_oe, .pc);

// ===== test/emb_mem_model.sv
// Purpose: external code and data memory with address latch
// Assumes: one byte array indexed by latched low byte xor high byte
// Notes: released port 0 goes high, as the pull-ups take it
`timescale 1ns/10ps
module emb_mem_model (input wire clock, ale, rd_b, wr_b, fetch_b, port0_oe,
  input wire [7:0] port0_out, input wire [7:0] port2_out, output wire [7:0] port0_in);
  reg [7:0] mem [0:255];
  reg [7:0] lat = 8'h00;
  wire [7:0] idx = lat ^ port2_out; // high byte folds into the index
  // memory answers only under a read strobe; a driven port 0 wins, elsewhere the pull-ups win
  assign port0_in = port0_oe ? port0_out : (!rd_b || !fetch_b) ? mem[idx] : 8'hFF;
  // latch low address on ale, store under the write strobe
  always @(posedge clock) begin
    if (ale) lat <= port0_out;
    if (!wr_b) mem[idx] <= port0_out;
  end
endmodule

// ===== test/testbench.sv
// Purpose: self-checking bench for the external bus strobe block
// Assumes: strap and pc change only while reset is held
// Notes: inputs move on the falling edge
`timescale 1ns/10ps
module testbench;
  reg clock = 1'b0, rst_b = 1'b0, strap = 1'b0, move_req = 1'b0, move_write = 1'b0;
  reg move_wide = 1'b0, prev;
  reg [15:0] pc = 16'h0100, move_addr = 16'h0000;
  reg [7:0] move_wdata = 8'h00;
  wire [7:0] port0_in, port0_out, port2_out, move_rdata;
  wire move_ack, fetch_b, ale, wr_b, rd_b, port0_oe;
  integer fails = 0, samples_checked = 0, i, nf, na;
  emb_strobes dut (.clock, .rst_b, .external_access_select(strap), .pc, .move_req, .move_write,
    .move_wide, .move_addr, .move_wdata, .port0_in, .move_ack, .move_rdata, .ale, .wr_b, .rd_b,
    .program_fetch_strobe_b(fetch_b), .port0_out, .port0_oe, .port2_out);
  emb_mem_model mem (.clock, .ale, .rd_b, .wr_b, .fetch_b, .port0_oe, .port0_out, .port2_out,
    .port0_in);
  initial forever #4 clock = ~clock;
  task check(input [7:0] seen, input [7:0] exp); begin
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  end endtask
  task tally_and_finish; begin
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  end endtask
  task do_reset(input s, input [15:0] p); begin
    rst_b = 1'b0;
    strap = s;
    pc = p;
    repeat (12) @(negedge clock);
    rst_b = 1'b1;
    repeat (2) @(negedge clock);
  end endtask
  // counts fetch strobes and ale pulses over two machine cycles
  task count_pulses(input [7:0] want); begin
    nf = 0;
    na = 0;
    prev = fetch_b;
    for (i = 0; i < 24; i = i + 1) begin
      @(negedge clock);
      nf = nf + (prev & ~fetch_b);
      na = na + ale;
      prev = fetch_b;
    end
    check(nf[7:0], want);
    check(na[7:0], 8'h04);
    $display("pulse count test done");
  end endtask
  // request held until acknowledged, as a refused boundary just delays it
  task move(input w, input wd, input [15:0] a, input [7:0] d); begin
    {move_write, move_wide, move_addr, move_wdata} = {w, wd, a, d};
    move_req = 1'b1;
    for (i = 0; i < 40 && move_ack !== 1'b1; i = i + 1) @(negedge clock);
    if (i == 40) begin
      fails = fails + 1;
      $display("unexpected at %0t: no move acknowledge", $time);
      tally_and_finish;
    end
    move_req = 1'b0;
    @(negedge clock);
  end endtask
  initial begin
    do_reset(1'b0, 16'h0100);
    count_pulses(8'h04);
    move(1'b1, 1'b0, 16'h0034, 8'hC3);
    move(1'b1, 1'b1, 16'h1234, 8'h5A);
    move(1'b0, 1'b0, 16'h0034, 8'h00);
    check(move_rdata, 8'hC3);
    move(1'b0, 1'b1, 16'h1234, 8'h00);
    check(move_rdata, 8'h5A);
    $display("data move test done");
    do_reset(1'b1, 16'h0100);
    count_pulses(8'h00);
    do_reset(1'b1, 16'h9000);
    count_pulses(8'h04);
    tally_and_finish;
  end
endmodule
